// >>> rtl/gct_bank.sv
// Five gated 16-bit counter/timers with a programmable frequency output.
// Assumes source and gate pins are asynchronous, and that the configuration
// and command ports are driven by logic on CLK_I.

// ----------------------------------------------------------------------------
// Top module
// ----------------------------------------------------------------------------
module gct_bank
	import gct_pkg::*;
(
	input  wire logic             CLK_I,        // 50 MHz clock.
	input  wire logic             NRST_I,       // Synchronous reset, active low.
	input  wire logic [4:0]       SRC_PIN_I,    // Count-source pins.
	input  wire logic [4:0]       GATE_PIN_I,   // Gating pins.
	input  wire logic             CFG_WE_I,     // Write mode settings.
	input  wire logic [2:0]       CFG_SEL_I,    // Counter addressed, 0 to 4.
	input  wire logic [3:0]       CFG_SRC_I,    // Source code.
	input  wire logic             CFG_EDGE_I,   // High counts rising edges.
	input  wire logic [3:0]       CFG_GATE_I,   // Gating mode.
	input  wire logic             CFG_TOGGLE_I, // High selects toggle output.
	input  wire logic             CFG_INVERT_I, // High inverts the output.
	input  wire logic             CFG_UP_I,     // High counts up.
	input  wire logic [CTR_W-1:0] CFG_LOAD_I,   // Load register value.
	input  wire logic [CTR_W-1:0] CFG_HOLD_I,   // Hold register value.
	input  wire logic             ARM_I,        // Arm the counter.
	input  wire logic             STOP_I,       // Stop the counter.
	input  wire logic             RESET_I,      // Reset command.
	input  wire logic [1:0]       RESET_IDLE_I, // Idle state for reset.
	input  wire logic             DIVIDED_FREQUENCY_OUTPUT_EN_I,    // Frequency output enable.
	input  wire logic [3:0]       DIVIDED_FREQUENCY_OUTPUT_SRC_I,   // 0-4 timebases, 5-9 source pins.
	input  wire logic [3:0]       DIVIDED_FREQUENCY_OUTPUT_DIV_I,   // Divide factor minus one.
	output logic      [4:0]       OUT_O,        // Counter output levels.
	output logic      [4:0]       OUT_OE_O,     // Counter output enables.
	output logic      [4:0]       RUNNING_O,    // Counter in run state.
	output logic      [CTR_W-1:0] COUNT_O,      // Count of addressed counter.
	output logic                  DIVIDED_FREQUENCY_OUTPUT_O // Divided clock.
);
	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	logic [9:0]       pin_s1_reg;
	logic [9:0]       pin_s2_reg;
	logic [9:0]       pin_s3_reg;
	logic [9:0]       pin_f_reg;
	logic [9:0]       pin_f_next;
	logic [4:0]       src_f;
	logic [4:0]       gate_f;
	logic [4:0]       pre_reg;
	logic [4:0]       pre_next;
	logic [2:0]       tbc_reg   [4:1];
	logic [2:0]       tbc_next  [4:1];
	logic [4:0]       tb_reg;
	logic [4:0]       tb_next;
	logic             tb_rise;
	gct_state_t       state_reg [NUM_CTR];
	gct_state_t       state_next[NUM_CTR];
	logic [3:0]       src_reg   [NUM_CTR];
	logic [3:0]       src_next  [NUM_CTR];
	logic [3:0]       gmode_reg [NUM_CTR];
	logic [3:0]       gmode_next[NUM_CTR];
	logic [CTR_W-1:0] load_reg  [NUM_CTR];
	logic [CTR_W-1:0] load_next [NUM_CTR];
	logic [CTR_W-1:0] hold_reg  [NUM_CTR];
	logic [CTR_W-1:0] hold_next [NUM_CTR];
	logic [1:0]       idle_reg  [NUM_CTR];
	logic [1:0]       idle_next [NUM_CTR];
	logic [4:0]       edge_reg, edge_next, tmode_reg, tmode_next;
	logic [4:0]       inv_reg, inv_next, up_reg, up_next;
	logic [4:0]       sprev_reg, sprev_next, gprev_reg, gprev_next;
	logic [4:0]       seen_reg, seen_next, pulse_reg, pulse_next;
	logic [4:0]       tog_reg, tog_next, out_reg, out_next, oe_reg, oe_next;
	logic [4:0]       run_reg, run_next;
	logic [4:0]       src_lvl, src_edge, level_ok, active, step, start, term;
	logic [15:0]      lvl_vec   [NUM_CTR];
	logic [CTR_W-1:0] reload    [NUM_CTR];
	logic [CTR_W-1:0] count     [NUM_CTR];
	logic [CTR_W-1:0] count_rd_reg;
	logic [CTR_W-1:0] count_rd_next;
	logic [9:0]       divided_frequency_output_vec;
	logic             divided_frequency_output_lvl, divided_frequency_output_prev_reg, divided_frequency_output_prev_next;
	logic [3:0]       divided_frequency_output_cnt_reg, divided_frequency_output_cnt_next;
	logic             divided_frequency_output_reg, divided_frequency_output_next;

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------
	// A level is taken only once the second and third stages agree, which
	// rejects a single-cycle glitch at the cost of one extra cycle of delay.
	always_comb begin
		pin_f_next = (pin_s2_reg & pin_s3_reg) | (pin_f_reg & (pin_s2_reg ^ pin_s3_reg));
	end

	// Three-stage chain for the ten asynchronous pins.
	always_ff @(posedge CLK_I) begin
		if (!NRST_I) begin
			pin_s1_reg <= 10'h000;
			pin_s2_reg <= 10'h000;
			pin_s3_reg <= 10'h000;
			pin_f_reg  <= 10'h000;
		end else begin
			pin_s1_reg <= {GATE_PIN_I, SRC_PIN_I};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			pin_f_reg  <= pin_f_next;
		end
	end

	assign src_f  = pin_f_reg[4:0];
	assign gate_f = pin_f_reg[9:5];

	// ------------------------------------------------------------------------
	// Timebases
	// ------------------------------------------------------------------------
	// First stage divides 50 MHz by fifty to a 1 MHz square wave; each further
	// stage toggles every fifth rising edge of the stage below, dividing by ten.
	always_comb begin
		tb_next  = tb_reg;
		pre_next = (pre_reg == TB1_HALF_LAST) ? 5'h00 : pre_reg + 5'h01;
		tb_rise  = (pre_reg == TB1_HALF_LAST) & ~tb_reg[0];
		if (pre_reg == TB1_HALF_LAST) begin
			tb_next[0] = ~tb_reg[0];
		end
		for (int k = 1; k < 5; k++) begin
			tbc_next[k] = tbc_reg[k];
			if (tb_rise) begin
				if (tbc_reg[k] == TB_DEC_LAST) begin
					tbc_next[k] = 3'h0;
					tb_next[k]  = ~tb_reg[k];
				end else begin
					tbc_next[k] = tbc_reg[k] + 3'h1;
				end
			end
			tb_rise = tb_rise & (tbc_reg[k] == TB_DEC_LAST) & ~tb_reg[k];
		end
	end

	// Timebase registers.
	always_ff @(posedge CLK_I) begin
		if (!NRST_I) begin
			pre_reg <= 5'h00;
			tb_reg  <= 5'h00;
			for (int k = 1; k < 5; k++) begin
				tbc_reg[k] <= 3'h0;
			end
		end else begin
			pre_reg <= pre_next;
			tb_reg  <= tb_next;
			for (int k = 1; k < 5; k++) begin
				tbc_reg[k] <= tbc_next[k];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Counter control
	// ------------------------------------------------------------------------
	// Gate levels are sampled on selected source edges only, so a gate change
	// waits up to one source period before it has any effect.
	always_comb begin
		for (int i = 0; i < NUM_CTR; i++) begin
			int lo;
			int hi;
			lo = (i == 0) ? NUM_CTR - 1 : i - 1;
			hi = (i == NUM_CTR - 1) ? 0 : i + 1;
			state_next[i] = state_reg[i];
			src_next[i]   = src_reg[i];
			gmode_next[i] = gmode_reg[i];
			load_next[i]  = load_reg[i];
			hold_next[i]  = hold_reg[i];
			idle_next[i]  = idle_reg[i];
			edge_next[i]  = edge_reg[i];
			tmode_next[i] = tmode_reg[i];
			inv_next[i]   = inv_reg[i];
			up_next[i]    = up_reg[i];
			lvl_vec[i]    = {tb_reg, gate_f, src_f, out_reg[lo]};
			src_lvl[i]    = lvl_vec[i][src_reg[i]];
			sprev_next[i] = src_lvl[i];
			gprev_next[i] = gate_f[i];
			src_edge[i]   = edge_reg[i] ? (src_lvl[i] & ~sprev_reg[i])
			                            : (~src_lvl[i] & sprev_reg[i]);
			case (gmode_reg[i])
				GATE_HIGH:    level_ok[i] = gate_f[i];
				GATE_LOW:     level_ok[i] = ~gate_f[i];
				GATE_TERM_LO: level_ok[i] = pulse_reg[lo];
				GATE_HIGHER:  level_ok[i] = gate_f[hi];
				GATE_LOWER:   level_ok[i] = gate_f[lo];
				default:      level_ok[i] = 1'b1;
			endcase
			// Edge gating remembers the gate transition until the next source edge.
			seen_next[i] = seen_reg[i];
			if ((state_reg[i] == GCT_ARMED) &&
			    (((gmode_reg[i] == GATE_RISE) && gate_f[i] && !gprev_reg[i]) ||
			     ((gmode_reg[i] == GATE_FALL) && !gate_f[i] && gprev_reg[i]))) begin
				seen_next[i] = 1'b1;
			end
			step[i]  = 1'b0;
			start[i] = 1'b0;
			case (state_reg[i])
				GCT_IDLE: begin
					if (ARM_I && (CFG_SEL_I == 3'(i)) && !RESET_I) begin
						start[i]      = 1'b1;
						state_next[i] = ((gmode_reg[i] == GATE_RISE) ||
						                 (gmode_reg[i] == GATE_FALL)) ? GCT_ARMED : GCT_RUN;
					end
				end
				GCT_ARMED: begin
					if (src_edge[i] && seen_reg[i]) begin
						step[i]       = 1'b1;
						seen_next[i]  = 1'b0;
						state_next[i] = GCT_RUN;
					end
				end
				GCT_RUN: begin
					step[i] = src_edge[i] & level_ok[i];
				end
				default: begin
					state_next[i] = GCT_IDLE;
				end
			endcase
			if (STOP_I && (CFG_SEL_I == 3'(i))) begin
				state_next[i] = GCT_IDLE;
				seen_next[i]  = 1'b0;
			end
			// Settings are accepted at any time, but take full effect only from
			// the next arm; writing while running can give one odd period.
			if (CFG_WE_I && (CFG_SEL_I == 3'(i))) begin
				src_next[i]   = CFG_SRC_I;
				gmode_next[i] = CFG_GATE_I;
				load_next[i]  = CFG_LOAD_I;
				hold_next[i]  = CFG_HOLD_I;
				edge_next[i]  = CFG_EDGE_I;
				tmode_next[i] = CFG_TOGGLE_I;
				inv_next[i]   = CFG_INVERT_I;
				up_next[i]    = CFG_UP_I;
			end
			if (RESET_I && (CFG_SEL_I == 3'(i))) begin
				state_next[i] = GCT_IDLE;
				src_next[i]   = SRC_LOWER;
				gmode_next[i] = GATE_NONE;
				edge_next[i]  = 1'b0;
				tmode_next[i] = 1'b0;
				inv_next[i]   = 1'b0;
				up_next[i]    = 1'b0;
				seen_next[i]  = 1'b0;
				idle_next[i]  = RESET_IDLE_I;
			end
			reload[i] = ((gmode_reg[i] == GATE_SPECIAL) && gate_f[i]) ? hold_reg[i]
			                                                          : load_reg[i];
			// Output forms: pulse marks the terminal source cycle, toggle flips
			// at the edge that ends that cycle.
			active[i]     = (state_reg[i] != GCT_IDLE);
			pulse_next[i] = 1'b0;
			tog_next[i]   = tog_reg[i];
			if (active[i]) begin
				pulse_next[i] = src_edge[i] ? term[i] : pulse_reg[i];
				if (src_edge[i] && pulse_reg[i]) begin
					tog_next[i] = ~tog_reg[i];
				end
			end
			if (RESET_I && (CFG_SEL_I == 3'(i))) begin
				tog_next[i] = 1'b0;
			end
			run_next[i] = (state_next[i] == GCT_RUN);
			if (state_next[i] != GCT_IDLE) begin
				oe_next[i]  = 1'b1;
				out_next[i] = (tmode_next[i] ? tog_next[i] : pulse_next[i]) ^ inv_next[i];
			end else begin
				oe_next[i]  = (idle_next[i] != IDLE_HIZ);
				out_next[i] = (idle_next[i] == IDLE_HIGH);
			end
		end
		count_rd_next = (CFG_SEL_I < 3'(NUM_CTR)) ? count[CFG_SEL_I] : CTR_ZERO;
	end

	// Counter control registers.
	always_ff @(posedge CLK_I) begin
		if (!NRST_I) begin
			for (int i = 0; i < NUM_CTR; i++) begin
				state_reg[i] <= GCT_IDLE;
				src_reg[i]   <= SRC_LOWER;
				gmode_reg[i] <= GATE_NONE;
				load_reg[i]  <= CTR_ZERO;
				hold_reg[i]  <= CTR_ZERO;
				idle_reg[i]  <= IDLE_RST;
			end
			{edge_reg, tmode_reg, inv_reg, up_reg} <= 20'h00000;
			{sprev_reg, gprev_reg, seen_reg, pulse_reg} <= 20'h00000;
			{tog_reg, out_reg, oe_reg, run_reg} <= 20'h00000;
			count_rd_reg <= CTR_ZERO;
		end else begin
			for (int i = 0; i < NUM_CTR; i++) begin
				state_reg[i] <= state_next[i];
				src_reg[i]   <= src_next[i];
				gmode_reg[i] <= gmode_next[i];
				load_reg[i]  <= load_next[i];
				hold_reg[i]  <= hold_next[i];
				idle_reg[i]  <= idle_next[i];
			end
			{edge_reg, tmode_reg, inv_reg, up_reg} <= {edge_next, tmode_next, inv_next, up_next};
			{sprev_reg, gprev_reg, seen_reg, pulse_reg} <=
				{sprev_next, gprev_next, seen_next, pulse_next};
			{tog_reg, out_reg, oe_reg, run_reg} <= {tog_next, out_next, oe_next, run_next};
			count_rd_reg <= count_rd_next;
		end
	end

	// One counting core per counter.
	for (genvar g = 0; g < NUM_CTR; g++) begin : g_ctr
		gct_counter u_ctr (
			.clk_i       (CLK_I),
			.nrst_i      (NRST_I),
			.start_i     (start[g]),
			.start_val_i (load_reg[g]),
			.step_i      (step[g]),
			.up_i        (up_reg[g]),
			.reload_i    (reload[g]),
			.count_o     (count[g]),
			.term_o      (term[g])
		);
	end

	// ------------------------------------------------------------------------
	// Frequency output
	// ------------------------------------------------------------------------
	// Output is high for the source high phase once every (factor) source periods;
	// factor one therefore copies the source. Factors above one are not 50 percent.
	always_comb begin
		divided_frequency_output_vec       = {src_f, tb_reg};
		divided_frequency_output_lvl       = (DIVIDED_FREQUENCY_OUTPUT_SRC_I < DIVIDED_FREQUENCY_OUTPUT_SRC_NUM) ? divided_frequency_output_vec[DIVIDED_FREQUENCY_OUTPUT_SRC_I] : 1'b0;
		divided_frequency_output_prev_next = divided_frequency_output_lvl;
		divided_frequency_output_cnt_next  = divided_frequency_output_cnt_reg;
		divided_frequency_output_next      = divided_frequency_output_reg;
		if (!DIVIDED_FREQUENCY_OUTPUT_EN_I) begin
			divided_frequency_output_cnt_next = 4'h0;
			divided_frequency_output_next     = 1'b0;
		end else if (divided_frequency_output_lvl && !divided_frequency_output_prev_reg) begin
			if (divided_frequency_output_cnt_reg >= DIVIDED_FREQUENCY_OUTPUT_DIV_I) begin
				divided_frequency_output_cnt_next = 4'h0;
				divided_frequency_output_next     = 1'b1;
			end else begin
				divided_frequency_output_cnt_next = divided_frequency_output_cnt_reg + 4'h1;
			end
		end else if (!divided_frequency_output_lvl && divided_frequency_output_prev_reg) begin
			divided_frequency_output_next = 1'b0;
		end
	end

	// Frequency output registers.
	always_ff @(posedge CLK_I) begin
		if (!NRST_I) begin
			divided_frequency_output_prev_reg <= 1'b0;
			divided_frequency_output_cnt_reg  <= 4'h0;
			divided_frequency_output_reg      <= 1'b0;
		end else begin
			divided_frequency_output_prev_reg <= divided_frequency_output_prev_next;
			divided_frequency_output_cnt_reg  <= divided_frequency_output_cnt_next;
			divided_frequency_output_reg      <= divided_frequency_output_next;
		end
	end

	assign OUT_O                      = out_reg;
	assign OUT_OE_O                   = oe_reg;
	assign RUNNING_O                  = run_reg;
	assign COUNT_O                    = count_rd_reg;
	assign DIVIDED_FREQUENCY_OUTPUT_O = divided_frequency_output_reg;

	// ------------------------------------------------------------------------
	// Assertions: timebases, counter 0 and frequency output
	// ------------------------------------------------------------------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);

	sequence gate_rise_armed_s;
		(state_reg[0] == GCT_ARMED) && (gmode_reg[0] == GATE_RISE) && gate_f[0] && !gprev_reg[0];
	endsequence

	sequence src_edge_seen_s;
		(state_reg[0] == GCT_ARMED) && src_edge[0] && seen_reg[0] && !STOP_I && !RESET_I;
	endsequence

	tb_period_a: assert property ($rose(tb_reg[0]) |-> ##50 $rose(tb_reg[0]))
		else $error("1 MHz timebase period is wrong.");
	tb_decade_a: assert property ($rose(tb_reg[1]) |-> ##1 (!$rose(tb_reg[1]))[*8])
		else $error("100 kHz timebase toggles too fast.");
	idle_out_a: assert property ((state_reg[0] == GCT_IDLE) |->
		(oe_reg[0] == (idle_reg[0] != IDLE_HIZ)) &&
		(out_reg[0] == (idle_reg[0] == IDLE_HIGH)))
		else $error("Idle output state does not match setting.");
	edge_start_a: assert property (gate_rise_armed_s ##[1:60] src_edge_seen_s |=>
		(state_reg[0] == GCT_RUN))
		else $error("Edge gating did not start at source edge.");
	level_gate_a: assert property ((state_reg[0] == GCT_RUN) &&
		(gmode_reg[0] == GATE_HIGH) && !gate_f[0] |=> (count[0] == $past(count[0])))
		else $error("Counted while gate was low.");
	pulse_term_a: assert property (term[0] && !RESET_I && !STOP_I |=> pulse_reg[0])
		else $error("Pulse missing after terminal count.");
	toggle_flip_a: assert property (active[0] && src_edge[0] && pulse_reg[0] &&
		!RESET_I |=> (tog_reg[0] != $past(tog_reg[0])))
		else $error("Toggle output did not change after terminal count.");
	reload_up_a: assert property (step[0] && up_reg[0] && (count[0] == CTR_MAX) &&
		!start[0] |=> (count[0] == $past(reload[0])))
		else $error("Counter did not reload on rollover.");
	special_hold_a: assert property (term[0] && (gmode_reg[0] == GATE_SPECIAL) &&
		gate_f[0] |=> (count[0] == $past(hold_reg[0])))
		else $error("Special gating picked the wrong reload value.");
	reset_cmd_a: assert property (RESET_I && (CFG_SEL_I == 3'h0) |=>
		(state_reg[0] == GCT_IDLE) && (gmode_reg[0] == GATE_NONE) &&
		(oe_reg[0] == ($past(RESET_IDLE_I) != IDLE_HIZ)) &&
		(out_reg[0] == ($past(RESET_IDLE_I) == IDLE_HIGH)))
		else $error("Reset command did not stop the counter.");
	nogate_arm_a: assert property ((state_reg[0] == GCT_IDLE) && ARM_I &&
		(CFG_SEL_I == 3'h0) && (gmode_reg[0] == GATE_NONE) && !RESET_I && !STOP_I |=>
		(state_reg[0] == GCT_RUN) && RUNNING_O[0] && (count[0] == $past(load_reg[0])))
		else $error("Ungated counter did not start on arm.");
	divided_frequency_output_off_a: assert property (!DIVIDED_FREQUENCY_OUTPUT_EN_I |=> !divided_frequency_output_reg && (divided_frequency_output_cnt_reg == 4'h0))
		else $error("Frequency output active while disabled.");
endmodule

// >>> rtl/gct_counter.sv
// Constants shared by the counter bank, and the single 16-bit counting core.
// Assumes one 50 MHz clock, a synchronous active-low reset, and a parent that
// already turns source activity into one-cycle step requests.

// ----------------------------------------------------------------------------
// Package
// ----------------------------------------------------------------------------
package gct_pkg;
	localparam int          NUM_CTR       = 5;
	localparam int          CTR_W         = 16;
	localparam int          CLK_HZ        = 50_000_000;
	localparam int          TB1_HZ        = 1_000_000;
	localparam logic [4:0]  TB1_HALF_LAST = 5'(CLK_HZ / (2 * TB1_HZ) - 1);
	localparam logic [2:0]  TB_DEC_LAST   = 3'h4;
	localparam logic [15:0] CTR_MAX       = 16'hFFFF;
	localparam logic [15:0] CTR_ZERO      = 16'h0000;
	// Source codes: 0 lower counter output, 1-5 source pins, 6-10 gate pins,
	// 11-15 timebases 1 to 5.
	localparam logic [3:0]  SRC_LOWER     = 4'h0;
	localparam logic [3:0]  DIVIDED_FREQUENCY_OUTPUT_SRC_NUM  = 4'hA;
	// Gating modes.
	localparam logic [3:0]  GATE_NONE     = 4'h0;
	localparam logic [3:0]  GATE_HIGH     = 4'h1;
	localparam logic [3:0]  GATE_LOW      = 4'h2;
	localparam logic [3:0]  GATE_RISE     = 4'h3;
	localparam logic [3:0]  GATE_FALL     = 4'h4;
	localparam logic [3:0]  GATE_TERM_LO  = 4'h5;
	localparam logic [3:0]  GATE_HIGHER   = 4'h6;
	localparam logic [3:0]  GATE_LOWER    = 4'h7;
	localparam logic [3:0]  GATE_SPECIAL  = 4'h8;
	// Idle output states.
	localparam logic [1:0]  IDLE_HIZ      = 2'h0;
	localparam logic [1:0]  IDLE_LOW      = 2'h1;
	localparam logic [1:0]  IDLE_HIGH     = 2'h2;
	localparam logic [1:0]  IDLE_RST      = IDLE_HIZ;
	typedef enum logic [2:0] {
		GCT_IDLE  = 3'b001,
		GCT_ARMED = 3'b010,
		GCT_RUN   = 3'b100
	} gct_state_t;
endpackage

// ----------------------------------------------------------------------------
// Counting core
// ----------------------------------------------------------------------------
module gct_counter
	import gct_pkg::*;
(
	input  wire logic             clk_i,      // System clock.
	input  wire logic             nrst_i,     // Synchronous reset, active low.
	input  wire logic             start_i,    // Load the start value.
	input  wire logic [CTR_W-1:0] start_val_i, // Start value.
	input  wire logic             step_i,     // One count event.
	input  wire logic             up_i,       // Count up when high.
	input  wire logic [CTR_W-1:0] reload_i,   // Value taken on rollover.
	output logic      [CTR_W-1:0] count_o,    // Current count.
	output logic                  term_o      // Rollover in this step.
);
	logic [CTR_W-1:0] count_reg;
	logic [CTR_W-1:0] count_next;
	logic             at_end;

	// Rollover point depends on direction; reload replaces the wrap value.
	always_comb begin
		at_end     = up_i ? (count_reg == CTR_MAX) : (count_reg == CTR_ZERO);
		term_o     = step_i & at_end;
		count_next = count_reg;
		if (start_i) begin
			count_next = start_val_i;
		end else if (step_i) begin
			if (at_end) begin
				count_next = reload_i;
			end else if (up_i) begin
				count_next = count_reg + 16'h0001;
			end else begin
				count_next = count_reg - 16'h0001;
			end
		end
	end

	// Count register.
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			count_reg <= CTR_ZERO;
		end else begin
			count_reg <= count_next;
		end
	end

	assign count_o = count_reg;
endmodule

// >>> verification/gct_pin_model.sv
// Pin-side model: one source pulse on source pin 0 per request, gate pin 0 level.
// Assumes requests come at least 16 clocks apart.
module gct_pin_model (
	input  wire logic       clk_i,  // Clock.
	input  wire logic       fire_i, // Request one source pulse.
	input  wire logic       gate_i, // Gate level wanted.
	output logic      [4:0] src_o,  // Source pins.
	output logic      [4:0] gate_o  // Gate pins.
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	// Eight clocks high, so the pin filter surely passes it; the pin then rests low.
	always @(posedge clk_i) begin
		if (fire_i) cnt <= 16;
		else if (cnt > 0) cnt <= cnt - 1;
	end
	assign src_o  = {4'h0, cnt > 8};
	assign gate_o = {4'h0, gate_i};
endmodule

// >>> verification/gct_bank_test.sv
// Self-checking bench for the counter bank, exercising counter 0.
// Assumes the pin model sits on the source and gate pins.
module gct_bank_test;
	import gct_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK_I = 0, NRST_I = 0, CFG_WE_I = 0, ARM_I = 0, RESET_I = 0, fire = 0, gate = 0;
	logic CFG_INVERT_I = 0, DIVIDED_FREQUENCY_OUTPUT_EN_I = 0;
	logic CFG_TOGGLE_I = 0, CFG_UP_I = 1, STOP_I = 0;
	logic [2:0] CFG_SEL_I = 3'h0;
	logic [3:0] DIVIDED_FREQUENCY_OUTPUT_SRC_I = 4'h5, DIVIDED_FREQUENCY_OUTPUT_DIV_I = 4'h1;
	logic [3:0] CFG_GATE_I = GATE_NONE;
	logic [1:0] RESET_IDLE_I = IDLE_HIGH;
	logic [4:0] src, gpin, OUT_O, OUT_OE_O, RUNNING_O;
	logic [15:0] COUNT_O;
	logic divided_frequency_output;
	int mismatches = 0, checked = 0, cycles = 0;
	// Free-running 50 MHz clock.
	always #10 CLK_I = ~CLK_I;
	gct_pin_model i_gct_pin_model (.clk_i(CLK_I), .fire_i(fire), .gate_i(gate),
		.src_o(src), .gate_o(gpin));
	gct_bank i_gct_bank (.CLK_I, .NRST_I, .SRC_PIN_I(src), .GATE_PIN_I(gpin), .CFG_WE_I,
		.CFG_SEL_I, .CFG_SRC_I(4'h1), .CFG_EDGE_I(1'b1), .CFG_GATE_I,
		.CFG_TOGGLE_I, .CFG_INVERT_I, .CFG_UP_I, .CFG_LOAD_I(16'hFFFD),
		.CFG_HOLD_I(16'h0000), .ARM_I, .STOP_I, .RESET_I, .RESET_IDLE_I, .DIVIDED_FREQUENCY_OUTPUT_EN_I,
		.DIVIDED_FREQUENCY_OUTPUT_SRC_I, .DIVIDED_FREQUENCY_OUTPUT_DIV_I, .OUT_O, .OUT_OE_O, .RUNNING_O, .COUNT_O,
		.DIVIDED_FREQUENCY_OUTPUT_O(divided_frequency_output));
	task check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge CLK_I);
	endtask
	task automatic cmd(ref logic s);
		s = 1;
		cyc(1);
		s = 0;
		cyc(1);
	endtask
	// One source pulse, then enough time for the filter and outputs to settle.
	task pulse();
		fire = 1;
		cyc(1);
		fire = 0;
		cyc(20);
	endtask
	task wrap_up();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Up count from FFFD without gating: rollover reloads and pulses once.
	task t_count();
		cmd(CFG_WE_I);
		cmd(ARM_I);
		check(RUNNING_O[0], 1'b1);
		pulse();
		pulse();
		check(COUNT_O, 16'hFFFF);
		check(OUT_O[0], 1'b0);
		pulse();
		check(COUNT_O, 16'hFFFD);
		check(OUT_O[0], 1'b1);
		pulse();
		check(OUT_O[0], 1'b0);
	endtask
	// High-level gating with inverted output: a low gate suspends counting.
	task t_gate();
		cmd(RESET_I);
		CFG_GATE_I = GATE_HIGH;
		CFG_INVERT_I = 1;
		cmd(CFG_WE_I);
		cmd(ARM_I);
		pulse();
		check(COUNT_O, 16'hFFFD);
		check(OUT_O[0], 1'b1);
		gate = 1;
		cyc(10);
		pulse();
		check(COUNT_O, 16'hFFFE);
	endtask
	// Rising-edge gating: the count waits for a gate rise, then starts at a source edge.
	task t_edge();
		cmd(RESET_I);
		gate = 0;
		CFG_GATE_I = GATE_RISE;
		CFG_INVERT_I = 0;
		cmd(CFG_WE_I);
		cyc(10);
		cmd(ARM_I);
		check(RUNNING_O[0], 1'b0);
		pulse();
		check(COUNT_O, 16'hFFFD);
		gate = 1;
		cyc(10);
		pulse();
		check(COUNT_O, 16'hFFFE);
		check(RUNNING_O[0], 1'b1);
	endtask
	// Toggle output: it flips at the source edge after the terminal count, not at it.
	task t_toggle();
		cmd(RESET_I);
		CFG_GATE_I = GATE_NONE;
		CFG_TOGGLE_I = 1;
		cmd(CFG_WE_I);
		cmd(ARM_I);
		repeat (3) pulse();
		check(COUNT_O, 16'hFFFD);
		check(OUT_O[0], 1'b0);
		pulse();
		check(OUT_O[0], 1'b1);
	endtask
	// Down count, stop to the idle state, then a second counter addressed on its own.
	task t_stop();
		cmd(RESET_I);
		CFG_TOGGLE_I = 0;
		CFG_UP_I = 0;
		cmd(CFG_WE_I);
		cmd(ARM_I);
		pulse();
		check(COUNT_O, 16'hFFFC);
		cmd(STOP_I);
		check({OUT_OE_O[0], OUT_O[0], RUNNING_O[0]}, 3'b110);
		pulse();
		check(COUNT_O, 16'hFFFC);
		CFG_SEL_I = 3'h1;
		CFG_UP_I = 1;
		cmd(CFG_WE_I);
		cmd(ARM_I);
		pulse();
		check(COUNT_O, 16'hFFFE);
		check(RUNNING_O, 5'h02);
		CFG_SEL_I = 3'h0;
		cyc(1);
		check(COUNT_O, 16'hFFFC);
	endtask
	// Divided output from the 1 MHz timebase by four: 200 clocks between rises.
	task t_divided_frequency_output();
		longint t0;
		DIVIDED_FREQUENCY_OUTPUT_SRC_I = 4'h0;
		DIVIDED_FREQUENCY_OUTPUT_DIV_I = 4'h3;
		DIVIDED_FREQUENCY_OUTPUT_EN_I = 1;
		@(posedge divided_frequency_output);
		t0 = $time;
		@(posedge divided_frequency_output);
		check(16'(($time - t0) / 20), 16'h00C8);
		cyc(1);
		DIVIDED_FREQUENCY_OUTPUT_EN_I = 0;
		cyc(2);
		check(divided_frequency_output, 1'b0);
	endtask
	// A timeout counts as a failure and closes the run.
	always @(posedge CLK_I) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			wrap_up();
		end
	end
	// Main sequence: reset, scenarios, reset command to a driven-high idle state.
	initial begin
		cyc(20);
		NRST_I = 1;
		cyc(1);
		check(OUT_OE_O, 5'h00);
		t_count();
		t_gate();
		t_edge();
		t_toggle();
		t_stop();
		t_divided_frequency_output();
		cmd(RESET_I);
		check({OUT_OE_O[0], OUT_O[0], RUNNING_O[0]}, 3'b110);
		check(divided_frequency_output, 1'b0);
		wrap_up();
	end
endmodule
